// ===== logic/clock_ctrl_pkg.sv
// Constants for the clock multiplier and oscillator auto-calibration block.
// Assumes an 8-bit register port with one byte per address.
package clock_ctrl_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_OSC_EN = 8'h00;
    localparam logic [7:0] OFF_READY  = 8'h01;
    localparam logic [7:0] OFF_MULT   = 8'h05;
    localparam logic [7:0] OFF_REFSEL = 8'h06;
    // Loop register windows: index 0 slow (2MHz), index 1 fast (32MHz)
    localparam logic [1:0][7:0] LOOP_BASE = {8'h10, 8'h18};
    localparam logic [2:0] LOFF_EN     = 3'h0;
    localparam logic [2:0] LOFF_FINE   = 3'h2;
    localparam logic [2:0] LOFF_COARSE = 3'h3;
    localparam logic [2:0] LOFF_RLO    = 3'h5;
    localparam logic [2:0] LOFF_RHI    = 3'h6;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int SRC_LSB     = 6;
    localparam int HALVE_BIT   = 5;
    localparam int PLL_EN_BIT  = 4;
    localparam int LOCKED_BIT  = 4;
    localparam int RDY_2M      = 0;
    localparam int RDY_32M     = 1;
    localparam int RDY_EXT     = 3;
    localparam logic [1:0] SRC_2M  = 2'h0;
    localparam logic [1:0] SRC_32M = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h3;
    localparam logic [1:0] FREF_INT  = 2'h0;
    localparam logic [1:0] FREF_XTAL = 2'h1;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [4:0] OSC_EN_RESET = 5'h01;
    localparam logic [1:0][15:0] RATIO_RESET = {16'h7A12, 16'h07A1};
    // 32 reference ticks of 32.768kHz make one 1.024kHz period
    localparam logic [4:0] REF_LAST_TICK = 5'h1F;
    localparam logic [6:0] FINE_MAX  = 7'h7F;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;

endpackage : clock_ctrl_pkg

// ===== logic/clock_ctrl.sv
// Clock multiplier configuration and two frequency-locked calibration loops.
// Assumes oscillator ticks and ready levels are synchronous to ref_clk.
module clock_ctrl (
    input  wire  logic              ref_clk,
    input  wire  logic              rst,
    input  wire  logic [7:0]        reg_addr,
    input  wire  logic [7:0]        reg_wdata,
    input  wire  logic              reg_wr,
    input  wire  logic              reg_rd,
    output logic       [7:0]        reg_rdata,
    input  wire  logic [3:0]        osc_ready,
    input  wire  logic              pll_lock_raw,
    input  wire  logic [1:0]        osc_tick,
    input  wire  logic              int32k_tick,
    input  wire  logic              xtal32k_tick,
    input  wire  logic [1:0][6:0]   factory_fine,
    input  wire  logic [1:0][5:0]   factory_coarse,
    output logic       [4:0]        osc_enable,
    output logic       [1:0]        multiplier_input_select,
    output logic       [4:0]        multiplier_factor,
    output logic                    multiplier_halve_output,
    output logic       [1:0]        pll_out_divisor,
    output logic                    multiplier_locked_flag,
    output logic       [1:0][12:0]  cal_trim,
    output logic       [1:0]        loop_active
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [4:0]  osc_en_q,  osc_en_d;
    logic [7:0]  mult_q,    mult_d;
    logic [2:0]  refsel_q,  refsel_d;
    logic        ready_q,   ready_d;
    logic [1:0]  div_q,     div_d;
    logic [7:0]  rdata_q,   rdata_d;
    logic        src_ok;
    logic        en_q    [2];
    logic        en_d    [2];
    logic [6:0]  fine_q  [2];
    logic [6:0]  fine_d  [2];
    logic [5:0]  coarse_q[2];
    logic [5:0]  coarse_d[2];
    logic [15:0] ratio_q [2];
    logic [15:0] ratio_d [2];
    logic [4:0]  pre_q   [2];
    logic [4:0]  pre_d   [2];
    logic [15:0] cnt_q   [2];
    logic [15:0] cnt_d   [2];
    logic        primed_q[2];
    logic        primed_d[2];
    logic        pend    [2];
    logic        rtick   [2];
    logic [7:0]  loop_rd [2];
    logic        rst_h_q;

    // Address match inside one loop window
    function automatic logic loop_hit(input logic [7:0] a, input logic [7:0] base,
                                      input logic [2:0] off);
        return a == (base + {5'h00, off});
    endfunction

    // ------------------------------------------------------------
    // Multiplier and shared registers
    // ------------------------------------------------------------

    // Next state of shared registers and the read path
    always_comb begin
        osc_en_d = osc_en_q;
        mult_d   = mult_q;
        refsel_d = refsel_q;
        if (reg_wr) begin
            if (reg_addr == clock_ctrl_pkg::OFF_OSC_EN) begin
                osc_en_d = reg_wdata[4:0];
            end else if (reg_addr == clock_ctrl_pkg::OFF_MULT) begin
                mult_d = reg_wdata;
            end else if (reg_addr == clock_ctrl_pkg::OFF_REFSEL) begin
                refsel_d = reg_wdata[2:0];
            end
        end
        div_d = mult_d[clock_ctrl_pkg::HALVE_BIT] ? 2'h2 : 2'h1;
        // Ready of the routed multiplier input
        case (mult_q[clock_ctrl_pkg::SRC_LSB +: 2])
            clock_ctrl_pkg::SRC_2M:  src_ok = osc_ready[clock_ctrl_pkg::RDY_2M];
            clock_ctrl_pkg::SRC_32M: src_ok = osc_ready[clock_ctrl_pkg::RDY_32M];
            clock_ctrl_pkg::SRC_EXT: src_ok = osc_ready[clock_ctrl_pkg::RDY_EXT];
            default:                 src_ok = 1'b0;
        endcase
        ready_d = osc_en_q[clock_ctrl_pkg::PLL_EN_BIT] && src_ok
                  && (mult_q[4:0] != 5'h00) && pll_lock_raw;
        rdata_d = 8'h00;
        if (reg_rd) begin
            if (reg_addr == clock_ctrl_pkg::OFF_OSC_EN) begin
                rdata_d = {3'h0, osc_en_q};
            end else if (reg_addr == clock_ctrl_pkg::OFF_READY) begin
                rdata_d = {3'h0, ready_q, osc_ready};
            end else if (reg_addr == clock_ctrl_pkg::OFF_MULT) begin
                rdata_d = mult_q;
            end else if (reg_addr == clock_ctrl_pkg::OFF_REFSEL) begin
                rdata_d = {5'h00, refsel_q};
            end else begin
                rdata_d = loop_rd[0] | loop_rd[1];
            end
        end
    end

    // Shared register storage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            osc_en_q <= clock_ctrl_pkg::OSC_EN_RESET;
            mult_q   <= 8'h00;
            refsel_q <= 3'h0;
            ready_q  <= 1'b0;
            div_q    <= 2'h1;
            rdata_q  <= 8'h00;
            rst_h_q  <= 1'b1;
        end else begin
            osc_en_q <= osc_en_d;
            mult_q   <= mult_d;
            refsel_q <= refsel_d;
            ready_q  <= ready_d;
            div_q    <= div_d;
            rdata_q  <= rdata_d;
            rst_h_q  <= 1'b0;
        end
    end

    assign reg_rdata               = rdata_q;
    assign osc_enable              = osc_en_q;
    assign multiplier_input_select = mult_q[clock_ctrl_pkg::SRC_LSB +: 2];
    assign multiplier_halve_output = mult_q[clock_ctrl_pkg::HALVE_BIT];
    assign multiplier_factor       = mult_q[4:0];
    assign pll_out_divisor         = div_q;
    assign multiplier_locked_flag  = ready_q;

    // ------------------------------------------------------------
    // Calibration loops
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_loop
        localparam logic [7:0] B = clock_ctrl_pkg::LOOP_BASE[i];

        // Reference selection, writes, counting and trim stepping
        always_comb begin
            if (i == 1) begin
                case (refsel_q[2:1])
                    clock_ctrl_pkg::FREF_INT:  rtick[i] = int32k_tick;
                    clock_ctrl_pkg::FREF_XTAL: rtick[i] = xtal32k_tick;
                    default:                   rtick[i] = 1'b0;
                endcase
            end else begin
                rtick[i] = refsel_q[0] ? xtal32k_tick : int32k_tick;
            end
            en_d[i]     = en_q[i];
            fine_d[i]   = fine_q[i];
            coarse_d[i] = coarse_q[i];
            ratio_d[i]  = ratio_q[i];
            pre_d[i]    = pre_q[i];
            cnt_d[i]    = cnt_q[i];
            primed_d[i] = primed_q[i];
            pend[i]     = 1'b0;
            if (reg_wr && loop_hit(reg_addr, B, clock_ctrl_pkg::LOFF_EN)) begin
                en_d[i] = reg_wdata[0];
            end
            if (reg_wr && loop_hit(reg_addr, B, clock_ctrl_pkg::LOFF_RLO)) begin
                ratio_d[i][7:0] = reg_wdata;
            end
            if (reg_wr && loop_hit(reg_addr, B, clock_ctrl_pkg::LOFF_RHI)) begin
                ratio_d[i][15:8] = reg_wdata;
            end
            if (!en_q[i]) begin
                // Manual trimming; loop counters held idle
                if (reg_wr && loop_hit(reg_addr, B, clock_ctrl_pkg::LOFF_FINE)) begin
                    fine_d[i] = reg_wdata[6:0];
                end
                if (reg_wr && loop_hit(reg_addr, B, clock_ctrl_pkg::LOFF_COARSE)) begin
                    coarse_d[i] = reg_wdata[5:0];
                end
                pre_d[i]    = 5'h00;
                cnt_d[i]    = 16'h0000;
                primed_d[i] = 1'b0;
            end else begin
                // Trim writes fall through untaken here
                if (osc_tick[i] && cnt_q[i] != clock_ctrl_pkg::CNT_MAX) begin
                    cnt_d[i] = cnt_q[i] + 16'h0001;
                end
                if (rtick[i]) begin
                    if (pre_q[i] == clock_ctrl_pkg::REF_LAST_TICK) begin
                        pend[i]     = 1'b1;
                        pre_d[i]    = 5'h00;
                        cnt_d[i]    = {15'h0000, osc_tick[i]};
                        primed_d[i] = 1'b1;
                        // First period after enable is partial and skipped
                        if (primed_q[i]) begin
                            if (cnt_q[i] < ratio_q[i] && fine_q[i] != clock_ctrl_pkg::FINE_MAX) begin
                                fine_d[i] = fine_q[i] + 7'h01;
                            end else if (cnt_q[i] > ratio_q[i] && fine_q[i] != 7'h00) begin
                                fine_d[i] = fine_q[i] - 7'h01;
                            end
                        end
                    end else begin
                        pre_d[i] = pre_q[i] + 5'h01;
                    end
                end
            end
            // Read path of the loop window
            loop_rd[i] = 8'h00;
            if (loop_hit(reg_addr, B, clock_ctrl_pkg::LOFF_EN)) begin
                loop_rd[i] = {7'h00, en_q[i]};
            end else if (loop_hit(reg_addr, B, clock_ctrl_pkg::LOFF_FINE)) begin
                loop_rd[i] = {1'b0, fine_q[i]};
            end else if (loop_hit(reg_addr, B, clock_ctrl_pkg::LOFF_COARSE)) begin
                loop_rd[i] = {2'h0, coarse_q[i]};
            end else if (loop_hit(reg_addr, B, clock_ctrl_pkg::LOFF_RLO)) begin
                loop_rd[i] = ratio_q[i][7:0];
            end else if (loop_hit(reg_addr, B, clock_ctrl_pkg::LOFF_RHI)) begin
                loop_rd[i] = ratio_q[i][15:8];
            end
        end

        // Loop state storage; trims take factory values at reset
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                en_q[i]     <= 1'b0;
                fine_q[i]   <= factory_fine[i];
                coarse_q[i] <= factory_coarse[i];
                ratio_q[i]  <= clock_ctrl_pkg::RATIO_RESET[i];
                pre_q[i]    <= 5'h00;
                cnt_q[i]    <= 16'h0000;
                primed_q[i] <= 1'b0;
            end else begin
                en_q[i]     <= en_d[i];
                fine_q[i]   <= fine_d[i];
                coarse_q[i] <= coarse_d[i];
                ratio_q[i]  <= ratio_d[i];
                pre_q[i]    <= pre_d[i];
                cnt_q[i]    <= cnt_d[i];
                primed_q[i] <= primed_d[i];
            end
        end

        assign cal_trim[i]    = {coarse_q[i], fine_q[i]};
        assign loop_active[i] = en_q[i];

        // Loop checks
        chk_fine_manual: assert property (@(posedge ref_clk) disable iff (rst)
            reg_wr && loop_hit(reg_addr, B, clock_ctrl_pkg::LOFF_FINE) && !en_q[i]
            |=> fine_q[i] == $past(reg_wdata[6:0]))
            else $error("fine trim write not taken while loop idle");
        chk_fine_frozen: assert property (@(posedge ref_clk) disable iff (rst)
            reg_wr && loop_hit(reg_addr, B, clock_ctrl_pkg::LOFF_FINE) && en_q[i]
            && !pend[i] |=> $stable(fine_q[i]))
            else $error("fine trim changed by write while loop runs");
        chk_coarse_hold: assert property (@(posedge ref_clk) disable iff (rst)
            en_q[i] |=> $stable(coarse_q[i]))
            else $error("coarse trim changed while loop runs");
        chk_factory_load: assert property (@(posedge ref_clk) disable iff (rst)
            rst_h_q |-> fine_q[i] == $past(factory_fine[i])
            && coarse_q[i] == $past(factory_coarse[i]))
            else $error("factory trim not loaded at reset");
        chk_ratio_reset: assert property (@(posedge ref_clk) disable iff (rst)
            rst_h_q && !$past(reg_wr) |-> ratio_q[i] == clock_ctrl_pkg::RATIO_RESET[i])
            else $error("target ratio wrong after reset");
        chk_step_up: assert property (@(posedge ref_clk) disable iff (rst)
            pend[i] && primed_q[i] && cnt_q[i] < ratio_q[i]
            && fine_q[i] != clock_ctrl_pkg::FINE_MAX
            |=> fine_q[i] == $past(fine_q[i]) + 7'h01)
            else $error("fine trim did not step up on slow count");
    end

    // ------------------------------------------------------------
    // Multiplier checks
    // ------------------------------------------------------------
    chk_locked_cause: assert property (@(posedge ref_clk) disable iff (rst)
        multiplier_locked_flag |-> $past(pll_lock_raw)
        && $past(osc_en_q[clock_ctrl_pkg::PLL_EN_BIT]))
        else $error("locked flag without lock and enable");
    chk_factor_zero: assert property (@(posedge ref_clk) disable iff (rst)
        multiplier_factor == 5'h00 |=> !multiplier_locked_flag)
        else $error("locked flag with zero factor");
    chk_reserved_src: assert property (@(posedge ref_clk) disable iff (rst)
        multiplier_input_select == 2'h1 |=> !multiplier_locked_flag)
        else $error("locked flag with reserved input code");
    chk_halve_div: assert property (@(posedge ref_clk) disable iff (rst)
        pll_out_divisor == (multiplier_halve_output ? 2'h2 : 2'h1))
        else $error("output divisor disagrees with halve bit");

endmodule // clock_ctrl

// ===== test/osc_partner.sv
// Behavioural model of the oscillators and lock detector that feed the clock block.
// Assumes enables come from the block and every tick is one ref_clk cycle long.
module osc_partner #(
    parameter int READY_DELAY = 4,  // Cycles from enable to ready
    parameter int REF_DIV     = 4   // ref_clk cycles per 32.768kHz reference tick
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [4:0] osc_enable,
    output logic      [3:0] osc_ready,
    output logic            pll_lock_raw,
    output logic      [1:0] osc_tick,
    output logic            int32k_tick,
    output logic            xtal32k_tick
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [4:0][3:0] up_q;
    logic [3:0]      div_q;

    // Start-up counters restart whenever a source is switched off
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            up_q  <= '0;
            div_q <= '0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (!osc_enable[i]) up_q[i] <= 4'h0;
                else if (up_q[i] != 4'(READY_DELAY)) up_q[i] <= up_q[i] + 4'h1;
            end
            div_q <= (div_q == 4'(REF_DIV - 1)) ? 4'h0 : div_q + 4'h1;
        end
    end

    // Oscillators tick once enabled and settled, references as soon as enabled; a disabled reference gives nothing
    always_comb begin
        for (int i = 0; i < 4; i++) osc_ready[i] = (up_q[i] == 4'(READY_DELAY));
        pll_lock_raw = (up_q[4] == 4'(READY_DELAY));
        osc_tick     = osc_enable[1:0] & osc_ready[1:0];
        int32k_tick  = osc_enable[2] && (div_q == 4'h0);
        // External source modelled well above 0.4MHz, sharing its enable bit 3 with the crystal reference ticks
        xtal32k_tick = osc_enable[3] && (div_q == 4'h0);
    end
endmodule // osc_partner

// ===== test/pll_and_osc_autocal_control_tb.sv
// Self-checking bench for the clock multiplier and calibration loop block.
// Assumes the block and the oscillator model share ref_clk at 10 MHz.
module pll_and_osc_autocal_control_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk, rst, reg_wr, reg_rd, pll_lock_raw, int32k_tick, xtal32k_tick;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
    logic [3:0] osc_ready;
    logic [1:0] osc_tick, multiplier_input_select, pll_out_divisor, loop_active;
    logic [1:0][6:0] factory_fine;
    logic [1:0][5:0] factory_coarse;
    logic [4:0] osc_enable, multiplier_factor;
    logic multiplier_halve_output, multiplier_locked_flag;
    logic [1:0][12:0] cal_trim;
    logic [12:0] trim_v;
    int fail_count, compares, seed;

    clock_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .osc_ready(osc_ready), .pll_lock_raw(pll_lock_raw), .osc_tick(osc_tick),
        .int32k_tick(int32k_tick), .xtal32k_tick(xtal32k_tick),
        .factory_fine(factory_fine), .factory_coarse(factory_coarse),
        .osc_enable(osc_enable), .multiplier_input_select(multiplier_input_select),
        .multiplier_factor(multiplier_factor), .multiplier_halve_output(multiplier_halve_output),
        .pll_out_divisor(pll_out_divisor), .multiplier_locked_flag(multiplier_locked_flag),
        .cal_trim(cal_trim), .loop_active(loop_active));

    osc_partner osc_u (.ref_clk(ref_clk), .rst(rst), .osc_enable(osc_enable),
        .osc_ready(osc_ready), .pll_lock_raw(pll_lock_raw), .osc_tick(osc_tick),
        .int32k_tick(int32k_tick), .xtal32k_tick(xtal32k_tick));

    // Clock generation
    always #50 ref_clk = ~ref_clk;

    // Comparison and verdict helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (fail_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Register port cycles, one strobe cycle each
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Expected lock state from input select code and factor, with every routed source assumed up
    function automatic logic exp_lock(input logic [1:0] src, input logic [4:0] fac);
        return (src != 2'h1) && (fac != 5'h00);
    endfunction

    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        finish_test();
    end

    initial begin
        seed = 32'h40160C1A;
        ref_clk = 1'b0; rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 8'h00; reg_wdata = 8'h00;
        factory_fine = 14'($random(seed));
        factory_coarse = 12'($random(seed));
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        #1 check(16'(cal_trim[0]), 16'({factory_coarse[0], factory_fine[0]}));
        check(16'(cal_trim[1]), 16'({factory_coarse[1], factory_fine[1]}));
        rd(clock_ctrl_pkg::OFF_OSC_EN, rd_v); check(16'(rd_v), 16'h0001);
        rd(clock_ctrl_pkg::OFF_REFSEL, rd_v); check(16'(rd_v), 16'h0000);
        rd(8'h03, rd_v); check(16'(rd_v), 16'h0000);
        rd(clock_ctrl_pkg::LOOP_BASE[1] + 8'h5, rd_v); check(16'(rd_v), 16'h0012);
        rd(clock_ctrl_pkg::LOOP_BASE[1] + 8'h6, rd_v); check(16'(rd_v), 16'h007A);
        rd(clock_ctrl_pkg::LOOP_BASE[0] + 8'h5, rd_v); check(16'(rd_v), 16'h00A1);
        // Random multiplier settings reach the outputs and read back
        for (int i = 0; i < 12; i++) begin
            reg_wdata <= 8'($random(seed));
            #1 trim_v = 13'(reg_wdata);
            wr(clock_ctrl_pkg::OFF_MULT, trim_v[7:0]);
            #1 check(16'(multiplier_input_select), 16'(trim_v[7:6]));
            check(16'(multiplier_factor), 16'(trim_v[4:0]));
            check(16'(pll_out_divisor), trim_v[5] ? 16'h2 : 16'h1);
            check(16'(multiplier_halve_output), 16'(trim_v[5]));
            rd(clock_ctrl_pkg::OFF_MULT, rd_v); check(16'(rd_v), 16'(trim_v[7:0]));
        end
        // Lock flag per input code, with all sources up except the internal 32k one
        wr(clock_ctrl_pkg::OFF_OSC_EN, 8'h1B);
        repeat (10) @(posedge ref_clk);
        for (int s = 0; s < 4; s++) begin
            for (int f = 0; f < 2; f++) begin
                wr(clock_ctrl_pkg::OFF_MULT, {2'(s), 1'b0, f ? 5'h1F : 5'h00});
                repeat (3) @(posedge ref_clk);
                check(16'(multiplier_locked_flag), 16'(exp_lock(2'(s), f ? 5'h1F : 5'h00)));
                rd(clock_ctrl_pkg::OFF_READY, rd_v);
                check(16'(rd_v[4]), 16'(exp_lock(2'(s), f ? 5'h1F : 5'h00)));
            end
        end
        // Slow loop on the crystal reference: manual trim, then automatic stepping
        wr(clock_ctrl_pkg::OFF_REFSEL, 8'h01);
        wr(clock_ctrl_pkg::LOOP_BASE[0] + 8'h2, 8'h40);
        wr(clock_ctrl_pkg::LOOP_BASE[0] + 8'h3, 8'h15);
        #1 check(16'(cal_trim[0]), 16'({6'h15, 7'h40}));
        wr(clock_ctrl_pkg::LOOP_BASE[0] + 8'h5, 8'h00);
        wr(clock_ctrl_pkg::LOOP_BASE[0] + 8'h6, 8'h00);
        rd(clock_ctrl_pkg::LOOP_BASE[0] + 8'h6, rd_v); check(16'(rd_v), 16'h0000);
        wr(clock_ctrl_pkg::LOOP_BASE[0], 8'h01);
        #1 check(16'(loop_active), 16'h1);
        wr(clock_ctrl_pkg::LOOP_BASE[0] + 8'h2, 8'h11);
        wr(clock_ctrl_pkg::LOOP_BASE[0] + 8'h3, 8'h01);
        #1 check(16'(cal_trim[0]), 16'({6'h15, 7'h40}));
        repeat (700) @(posedge ref_clk);
        trim_v = cal_trim[0];
        check(16'(trim_v[6:0] < 7'h40), 16'h1);
        check(16'(trim_v[12:7]), 16'h15);
        wr(clock_ctrl_pkg::LOOP_BASE[0] + 8'h5, 8'hFF);
        wr(clock_ctrl_pkg::LOOP_BASE[0] + 8'h6, 8'hFF);
        repeat (700) @(posedge ref_clk);
        check(16'(cal_trim[0][6:0] > trim_v[6:0]), 16'h1);
        check(16'(cal_trim[0][12:7]), 16'h15);
        wr(clock_ctrl_pkg::LOOP_BASE[0], 8'h00);
        // Fast loop: reserved reference never steps, internal reference does
        wr(clock_ctrl_pkg::OFF_OSC_EN, 8'h1F);
        wr(clock_ctrl_pkg::OFF_REFSEL, 8'h04);
        wr(clock_ctrl_pkg::LOOP_BASE[1] + 8'h5, 8'h00);
        wr(clock_ctrl_pkg::LOOP_BASE[1] + 8'h6, 8'h00);
        wr(clock_ctrl_pkg::LOOP_BASE[1], 8'h01);
        trim_v = cal_trim[1];
        repeat (700) @(posedge ref_clk);
        check(16'(cal_trim[1]), 16'(trim_v));
        wr(clock_ctrl_pkg::OFF_REFSEL, 8'h00);
        repeat (700) @(posedge ref_clk);
        check(16'(cal_trim[1][6:0] < trim_v[6:0] || trim_v[6:0] == 7'h00), 16'h1);
        check(16'(cal_trim[1][12:7]), 16'(trim_v[12:7]));
        // Retarget the fast loop to its nominal 32MHz ratio and read it back
        wr(clock_ctrl_pkg::LOOP_BASE[1] + 8'h5, 8'h12);
        wr(clock_ctrl_pkg::LOOP_BASE[1] + 8'h6, 8'h7A);
        rd(clock_ctrl_pkg::LOOP_BASE[1] + 8'h5, rd_v); check(16'(rd_v), 16'h0012);
        rd(clock_ctrl_pkg::LOOP_BASE[1] + 8'h6, rd_v); check(16'(rd_v), 16'h007A);
        finish_test();
    end
endmodule // pll_and_osc_autocal_control_tb
